// ===== src/reload_timer_pkg.sv
// constants, field layout and clock-source codes of the reload timer
// assumes an 8-bit special-function-register bus on the system clock
//
// Operation
// - high byte wrap sets high overflow flag
// - enabled timer irq requests on high flag
// - hardware never clears high flag; software does
// - low byte wrap sets low overflow flag
// - low flag irq needs both enables set
// - low flag stays set until software clears
// - split bit selects 16-bit or dual 8-bit
// - run gates counting; split low always runs
// - alternate clock: system_clock/12 or external/8
// - split: external select shared, byte override
// - two readable writable reload bytes
// - count bytes readable and writable
// - control bits 4 and 1 read zero
// - 16-bit wrap loads 16-bit reload value
// - split wrap reloads each byte separately
// - byte system_clock select picks system clock
// - one timer irq enable gates requests
package reload_timer_pkg;

  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'hC8;
  localparam logic [7:0] ADDR_RELOAD_LO = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HI = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LO  = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HI  = 8'hCD;

  // ------------------------------------------------------------
  // control/status fields
  // ------------------------------------------------------------
  localparam int         BIT_HI_FLAG     = 7;
  localparam int         BIT_LO_FLAG     = 6;
  localparam int         BIT_LO_IRQ_EN   = 5;
  localparam int         BIT_SPLIT       = 3;
  localparam int         BIT_RUN         = 2;
  localparam int         BIT_EXT_SEL     = 0;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hED;

  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] COUNT_RESET     = 8'h00;
  localparam logic [7:0] RELOAD_RESET    = 8'h00;
  localparam logic [7:0] BYTE_MAX        = 8'hFF;
  localparam logic [3:0] SYSTEM_CLOCK_DIV_LAST = 4'hB;
  localparam logic [2:0] EXT_DIV_LAST    = 3'h7;

  typedef enum logic [1:0] {SRC_SYSTEM_CLOCK, SRC_SYSTEM_CLOCK_DIV12, SRC_EXT_DIV8} clk_src_t;

endpackage : reload_timer_pkg

// ===== src/count_enable_gen.sv
// count-enable divider: system_clock/12 and synchronised external/8
// assumes the external oscillator is no faster than half of mclk
module count_enable_gen
  import reload_timer_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic extOscIn,
  output logic      div12Tick,
  output logic      ext8Tick
);

  logic       sync1_reg,  sync1_next;
  logic       sync2_reg,  sync2_next;
  logic       prev_reg,   prev_next;
  logic [3:0] div12_reg,  div12_next;
  logic [2:0] ext8_reg,   ext8_next;
  logic       tick12_reg, tick12_next;
  logic       tick8_reg,  tick8_next;

  // ------------------------------------------------------------
  // dividers
  // ------------------------------------------------------------
  always_comb
  begin
    sync1_next  = extOscIn;
    sync2_next  = sync1_reg;
    prev_next   = sync2_reg;
    div12_next  = div12_reg + 4'h1;
    tick12_next = 1'b0;
    ext8_next   = ext8_reg;
    tick8_next  = 1'b0;
    if (div12_reg == SYSTEM_CLOCK_DIV_LAST)
    begin
      div12_next  = 4'h0;
      tick12_next = 1'b1;
    end
    if (sync2_reg && !prev_reg)
    begin
      ext8_next = ext8_reg + 3'h1;
      if (ext8_reg == EXT_DIV_LAST)
      begin
        tick8_next = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      sync1_reg  <= 1'b0;
      sync2_reg  <= 1'b0;
      prev_reg   <= 1'b0;
      div12_reg  <= 4'h0;
      ext8_reg   <= 3'h0;
      tick12_reg <= 1'b0;
      tick8_reg  <= 1'b0;
    end
    else
    begin
      sync1_reg  <= sync1_next;
      sync2_reg  <= sync2_next;
      prev_reg   <= prev_next;
      div12_reg  <= div12_next;
      ext8_reg   <= ext8_next;
      tick12_reg <= tick12_next;
      tick8_reg  <= tick8_next;
    end
  end

  assign div12Tick = tick12_reg;
  assign ext8Tick  = tick8_reg;

  div12Period_a: assert property (@(posedge mclk) disable iff (!rst_b)
    div12Tick |=> !div12Tick [*8] ##1 !div12Tick [*3] ##1 div12Tick)
    else $error("system_clock/12 tick spacing wrong");

  ext8Pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ext8Tick |=> !ext8Tick)
    else $error("external/8 tick longer than one cycle");

endmodule : count_enable_gen

// ===== src/reload_timer.sv
// auto-reload timer, 16-bit or split into two 8-bit counters
// assumes a one-cycle register write strobe and registered read data
module reload_timer
  import reload_timer_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrEn,
  input  wire logic [7:0] sfrWrData,
  output logic      [7:0] sfrRdData,
  input  wire logic       highByteSysclkSelect,
  input  wire logic       lowByteSysclkSelect,
  input  wire logic       timerIrqEnable,
  input  wire logic       extOscIn,
  output logic            timerIrq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] ctrl_reg,     ctrl_next;
  logic [7:0] reloadLo_reg, reloadLo_next;
  logic [7:0] reloadHi_reg, reloadHi_next;
  logic [7:0] countLo_reg,  countLo_next;
  logic [7:0] countHi_reg,  countHi_next;
  logic [7:0] rdData_reg,   rdData_next;

  logic       div12Tick;
  logic       ext8Tick;
  logic       wrCtrl;
  logic       wrCountLo;
  logic       wrCountHi;
  logic       splitMode;
  logic       runCtrl;
  logic       lowSrcTick;
  logic       highSrcTick;
  logic       lowTick;
  logic       highTick;
  logic       loWrap;
  logic       hiWrap;
  logic [15:0] count16;

  // ------------------------------------------------------------
  // clock source choice
  // ------------------------------------------------------------
  function automatic logic pickTick(input logic sysSel, input logic extSel,
                                    input logic tick12, input logic tick8);
    clk_src_t src;
    src = sysSel ? SRC_SYSTEM_CLOCK : (extSel ? SRC_EXT_DIV8 : SRC_SYSTEM_CLOCK_DIV12);
    case (src)
      SRC_SYSTEM_CLOCK:       pickTick = 1'b1;
      SRC_SYSTEM_CLOCK_DIV12: pickTick = tick12;
      SRC_EXT_DIV8:     pickTick = tick8;
      default:          pickTick = 1'b0;
    endcase
  endfunction : pickTick

  count_enable_gen i_count_enable_gen (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .extOscIn  (extOscIn),
    .div12Tick (div12Tick),
    .ext8Tick  (ext8Tick)
  );

  assign wrCtrl    = sfrWrEn && (sfrAddr == ADDR_CTRL);
  assign wrCountLo = sfrWrEn && (sfrAddr == ADDR_COUNT_LO);
  assign wrCountHi = sfrWrEn && (sfrAddr == ADDR_COUNT_HI);
  assign splitMode = ctrl_reg[BIT_SPLIT];
  assign runCtrl   = ctrl_reg[BIT_RUN];
  assign count16   = {countHi_reg, countLo_reg};

  // low-byte select also clocks the whole 16-bit counter
  assign lowSrcTick = pickTick(lowByteSysclkSelect, ctrl_reg[BIT_EXT_SEL],
                               div12Tick, ext8Tick);
  assign highSrcTick = pickTick(highByteSysclkSelect, ctrl_reg[BIT_EXT_SEL],
                                div12Tick, ext8Tick);

  // ------------------------------------------------------------
  // count enables and wraps
  // ------------------------------------------------------------
  assign lowTick  = splitMode ? lowSrcTick : (runCtrl && lowSrcTick);
  assign highTick = splitMode && runCtrl && highSrcTick;
  assign loWrap   = lowTick && (countLo_reg == BYTE_MAX);
  assign hiWrap   = splitMode ? (highTick && (countHi_reg == BYTE_MAX))
                              : (loWrap && (countHi_reg == BYTE_MAX));

  // ------------------------------------------------------------
  // counters, reloads and control
  // ------------------------------------------------------------
  always_comb
  begin
    ctrl_next     = ctrl_reg;
    reloadLo_next = reloadLo_reg;
    reloadHi_next = reloadHi_reg;
    countLo_next  = countLo_reg;
    countHi_next  = countHi_reg;
    if (splitMode)
    begin
      if (lowTick)
      begin
        countLo_next = loWrap ? reloadLo_reg : countLo_reg + 8'h01;
      end
      if (highTick)
      begin
        countHi_next = hiWrap ? reloadHi_reg : countHi_reg + 8'h01;
      end
    end
    else if (lowTick)
    begin
      if (hiWrap)
      begin
        {countHi_next, countLo_next} = {reloadHi_reg, reloadLo_reg};
      end
      else
      begin
        {countHi_next, countLo_next} = count16 + 16'h0001;
      end
    end
    // software write overrides any count or reload this cycle
    if (wrCountLo)
    begin
      countLo_next = sfrWrData;
    end
    if (wrCountHi)
    begin
      countHi_next = sfrWrData;
    end
    if (sfrWrEn && (sfrAddr == ADDR_RELOAD_LO))
    begin
      reloadLo_next = sfrWrData;
    end
    if (sfrWrEn && (sfrAddr == ADDR_RELOAD_HI))
    begin
      reloadHi_next = sfrWrData;
    end
    if (wrCtrl)
    begin
      ctrl_next = (sfrWrData & CTRL_WRITE_MASK) | (ctrl_reg & ~CTRL_WRITE_MASK);
    end
    // hardware set wins over a software clear in the same cycle
    if (hiWrap)
    begin
      ctrl_next[BIT_HI_FLAG] = 1'b1;
    end
    if (loWrap)
    begin
      ctrl_next[BIT_LO_FLAG] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_comb
  begin
    case (sfrAddr)
      ADDR_CTRL:      rdData_next = ctrl_reg & CTRL_WRITE_MASK;
      ADDR_RELOAD_LO: rdData_next = reloadLo_reg;
      ADDR_RELOAD_HI: rdData_next = reloadHi_reg;
      ADDR_COUNT_LO:  rdData_next = countLo_reg;
      ADDR_COUNT_HI:  rdData_next = countHi_reg;
      default:        rdData_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ctrl_reg     <= CTRL_RESET;
      reloadLo_reg <= RELOAD_RESET;
      reloadHi_reg <= RELOAD_RESET;
      countLo_reg  <= COUNT_RESET;
      countHi_reg  <= COUNT_RESET;
      rdData_reg   <= 8'h00;
    end
    else
    begin
      ctrl_reg     <= ctrl_next;
      reloadLo_reg <= reloadLo_next;
      reloadHi_reg <= reloadHi_next;
      countLo_reg  <= countLo_next;
      countHi_reg  <= countHi_next;
      rdData_reg   <= rdData_next;
    end
  end

  assign sfrRdData = rdData_reg;

  // ------------------------------------------------------------
  // interrupt request
  // ------------------------------------------------------------
  assign timerIrq = timerIrqEnable &&
                    (ctrl_reg[BIT_HI_FLAG] ||
                     (ctrl_reg[BIT_LO_FLAG] && ctrl_reg[BIT_LO_IRQ_EN]));

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  hiFlagSet_a: assert property (@(posedge mclk) disable iff (!rst_b)
    hiWrap |=> ctrl_reg[BIT_HI_FLAG])
    else $error("high overflow flag not set on wrap");

  hiIrqReq_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ($rose(ctrl_reg[BIT_HI_FLAG]) && timerIrqEnable) |-> timerIrq)
    else $error("no interrupt on high overflow");

  hiFlagHold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (ctrl_reg[BIT_HI_FLAG] && !wrCtrl) |=> ctrl_reg[BIT_HI_FLAG])
    else $error("high overflow flag cleared by hardware");

  loFlagSet_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (lowTick && countLo_reg == BYTE_MAX) |=> ctrl_reg[BIT_LO_FLAG])
    else $error("low overflow flag not set on wrap");

  loIrqGate_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (timerIrq && !ctrl_reg[BIT_HI_FLAG]) |->
      (timerIrqEnable && ctrl_reg[BIT_LO_IRQ_EN] && ctrl_reg[BIT_LO_FLAG]))
    else $error("low overflow interrupt without enables");

  loFlagHold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (ctrl_reg[BIT_LO_FLAG] && !wrCtrl) |=> ctrl_reg[BIT_LO_FLAG])
    else $error("low overflow flag cleared by hardware");

  stopHold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (!splitMode && !runCtrl && !wrCtrl && !wrCountLo && !wrCountHi)
      |=> $stable(count16))
    else $error("16-bit counter moved while stopped");

  splitLowRun_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (splitMode && !runCtrl && lowByteSysclkSelect && !wrCountLo &&
     countLo_reg != BYTE_MAX) |=> countLo_reg == $past(countLo_reg) + 8'h01)
    else $error("split low byte not running");

  reload16_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (!splitMode && lowTick && count16 == 16'hFFFF && !wrCountLo && !wrCountHi)
      |=> count16 == {$past(reloadHi_reg), $past(reloadLo_reg)})
    else $error("16-bit reload value not loaded");

  reloadSplit_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (splitMode && highTick && countHi_reg == BYTE_MAX && !wrCountHi)
      |=> countHi_reg == $past(reloadHi_reg))
    else $error("split high byte not reloaded");

  unusedZero_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sfrAddr == ADDR_CTRL) |=> (sfrRdData & ~CTRL_WRITE_MASK) == 8'h00)
    else $error("unused control bits read nonzero");

  writeWins_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wrCountLo |=> countLo_reg == $past(sfrWrData))
    else $error("software count write lost");

  irqGlobalOff_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !timerIrqEnable |-> !timerIrq)
    else $error("interrupt request while timer interrupts disabled");

  loIrqRaise_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (timerIrqEnable && ctrl_reg[BIT_LO_IRQ_EN] && ctrl_reg[BIT_LO_FLAG]) |-> timerIrq)
    else $error("no interrupt on enabled low overflow");

  splitHighStop_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (splitMode && !runCtrl && !wrCountHi) |=> $stable(countHi_reg))
    else $error("split high byte moved while stopped");

  splitLowReload_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (splitMode && lowTick && countLo_reg == BYTE_MAX && !wrCountLo)
      |=> countLo_reg == $past(reloadLo_reg))
    else $error("split low byte not reloaded");

  writeWinsHi_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wrCountHi |=> countHi_reg == $past(sfrWrData))
    else $error("software high count write lost");

  reloadWrite_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sfrWrEn && sfrAddr == ADDR_RELOAD_LO) |=> reloadLo_reg == $past(sfrWrData))
    else $error("reload low write lost");

  reloadHold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !(sfrWrEn && sfrAddr == ADDR_RELOAD_HI) |=> $stable(reloadHi_reg))
    else $error("reload high changed without write");

  countRead_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sfrAddr == ADDR_COUNT_LO) |=> sfrRdData == $past(countLo_reg))
    else $error("count low read data wrong");

  count16Inc_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (!splitMode && lowTick && count16 != 16'hFFFF && !wrCountLo && !wrCountHi)
      |=> count16 == $past(count16) + 16'h0001)
    else $error("16-bit counter did not increment");

  splitHighInc_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (splitMode && highTick && countHi_reg != BYTE_MAX && !wrCountHi)
      |=> countHi_reg == $past(countHi_reg) + 8'h01)
    else $error("split high byte did not increment");

  extHighGate_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (splitMode && runCtrl && !highByteSysclkSelect && ctrl_reg[BIT_EXT_SEL] &&
     !ext8Tick && !wrCountHi) |=> $stable(countHi_reg))
    else $error("split high byte moved without external tick");

  div12Gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (!splitMode && runCtrl && !lowByteSysclkSelect && !ctrl_reg[BIT_EXT_SEL] &&
     !div12Tick && !wrCountLo && !wrCountHi) |=> $stable(count16))
    else $error("16-bit counter moved without divided tick");

endmodule : reload_timer

// ===== sim/reload_timer_tb.sv
// self-checking bench for the reload timer: register access, 16-bit and split counting
// assumes the register map and control field layout of reload_timer_pkg
module reload_timer_tb
  import reload_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end

  logic       mclk;
  logic       rst_b;
  logic [7:0] sfrAddr;
  logic       sfrWrEn;
  logic [7:0] sfrWrData;
  logic [7:0] sfrRdData;
  logic       highByteSysclkSelect;
  logic       lowByteSysclkSelect;
  logic       timerIrqEnable;
  logic       extOscIn;
  logic       timerIrq;
  logic [7:0] rdVal;
  int         num_errors;
  int         n_compared;

  reload_timer i_reload_timer (
    .mclk                 (mclk),
    .rst_b                (rst_b),
    .sfrAddr              (sfrAddr),
    .sfrWrEn              (sfrWrEn),
    .sfrWrData            (sfrWrData),
    .sfrRdData            (sfrRdData),
    .highByteSysclkSelect (highByteSysclkSelect),
    .lowByteSysclkSelect  (lowByteSysclkSelect),
    .timerIrqEnable       (timerIrqEnable),
    .extOscIn             (extOscIn),
    .timerIrq             (timerIrq)
  );

  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfrAddr   <= a;
    sfrWrData <= d;
    sfrWrEn   <= 1'b1;
    @(posedge mclk);
    sfrWrEn   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    sfrAddr <= a;
    @(posedge mclk);
    @(negedge mclk);
    d = sfrRdData;
  endtask : rd

  // external oscillator, five system clocks per period
  task automatic ext_edges(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      extOscIn <= 1'b1;
      repeat (2) @(posedge mclk);
      extOscIn <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    repeat (10) @(posedge mclk);
  endtask : ext_edges

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic reset_values();
    logic [7:0] addrs [6];
    addrs = '{ADDR_CTRL, ADDR_RELOAD_LO, ADDR_RELOAD_HI, ADDR_COUNT_LO, ADDR_COUNT_HI, 8'hC9};
    foreach (addrs[i])
    begin
      rd(addrs[i], rdVal);
      `CHK("reset value", 8'h00, rdVal)
    end
    `CHK("irq after reset", 1'b0, timerIrq)
  endtask : reset_values

  task automatic register_access();
    wr(ADDR_RELOAD_LO, 8'hA5);
    wr(ADDR_RELOAD_HI, 8'h5A);
    wr(ADDR_COUNT_LO, 8'h3C);
    wr(ADDR_COUNT_HI, 8'hC3);
    wr(8'hC9, 8'hFF);
    rd(ADDR_RELOAD_LO, rdVal);
    `CHK("reload low", 8'hA5, rdVal)
    rd(ADDR_RELOAD_HI, rdVal);
    `CHK("reload high", 8'h5A, rdVal)
    rd(ADDR_COUNT_LO, rdVal);
    `CHK("count low", 8'h3C, rdVal)
    rd(ADDR_COUNT_HI, rdVal);
    `CHK("count high", 8'hC3, rdVal)
    rd(8'hC9, rdVal);
    `CHK("unmapped", 8'h00, rdVal)
  endtask : register_access

  task automatic irq_gating();
    @(posedge mclk);
    timerIrqEnable <= 1'b1;
    wr(ADDR_CTRL, 8'h40);
    rd(ADDR_CTRL, rdVal);
    `CHK("low flag kept", 8'h40, rdVal)
    `CHK("low flag silent", 1'b0, timerIrq)
    wr(ADDR_CTRL, 8'hFF);
    rd(ADDR_CTRL, rdVal);
    `CHK("control unused bits", 8'hED, rdVal)
    `CHK("irq enabled", 1'b1, timerIrq)
    @(posedge mclk);
    timerIrqEnable <= 1'b0;
    @(negedge mclk);
    `CHK("irq global gate", 1'b0, timerIrq)
    @(posedge mclk);
    timerIrqEnable <= 1'b1;
    wr(ADDR_CTRL, 8'h00);
    @(negedge mclk);
    `CHK("irq after clear", 1'b0, timerIrq)
  endtask : irq_gating

  task automatic wrap_16bit();
    @(posedge mclk);
    lowByteSysclkSelect <= 1'b0;
    wr(ADDR_RELOAD_LO, 8'h34);
    wr(ADDR_RELOAD_HI, 8'h12);
    wr(ADDR_COUNT_LO, 8'hFF);
    wr(ADDR_COUNT_HI, 8'hFF);
    wr(ADDR_CTRL, 8'h04);
    for (int i = 0; i < 40 && timerIrq !== 1'b1; i++) @(negedge mclk);
    `CHK("high overflow irq", 1'b1, timerIrq)
    rd(ADDR_CTRL, rdVal);
    `CHK("16-bit wrap flags", 8'hC4, rdVal)
    wr(ADDR_CTRL, 8'hC0);
    repeat (30) @(posedge mclk);
    rd(ADDR_COUNT_LO, rdVal);
    `CHK("16-bit reload low", 8'h34, rdVal)
    rd(ADDR_COUNT_HI, rdVal);
    `CHK("16-bit reload high", 8'h12, rdVal)
    rd(ADDR_CTRL, rdVal);
    `CHK("both flags held", 8'hC0, rdVal)
    wr(ADDR_CTRL, 8'h00);
  endtask : wrap_16bit

  task automatic split_mode();
    highByteSysclkSelect <= 1'b1;
    wr(ADDR_RELOAD_LO, 8'hFE);
    wr(ADDR_RELOAD_HI, 8'hF0);
    wr(ADDR_COUNT_LO, 8'hFE);
    wr(ADDR_COUNT_HI, 8'hFE);
    wr(ADDR_CTRL, 8'h09);
    ext_edges(8);
    rd(ADDR_COUNT_LO, rdVal);
    `CHK("ext div8 one tick", 8'hFF, rdVal)
    ext_edges(8);
    rd(ADDR_COUNT_LO, rdVal);
    `CHK("split low reload", 8'hFE, rdVal)
    rd(ADDR_COUNT_HI, rdVal);
    `CHK("high gated by run", 8'hFE, rdVal)
    rd(ADDR_CTRL, rdVal);
    `CHK("low flag only", 8'h49, rdVal)
    @(posedge mclk);
    highByteSysclkSelect <= 1'b0;
    wr(ADDR_CTRL, 8'h0D);
    ext_edges(16);
    rd(ADDR_COUNT_HI, rdVal);
    `CHK("split high reload", 8'hF0, rdVal)
    rd(ADDR_COUNT_LO, rdVal);
    `CHK("split low again", 8'hFE, rdVal)
    rd(ADDR_CTRL, rdVal);
    `CHK("both split flags", 8'hCD, rdVal)
    wr(ADDR_CTRL, 8'h0D);
    highByteSysclkSelect <= 1'b1;
    for (int i = 0; i < 40 && timerIrq !== 1'b1; i++) @(negedge mclk);
    `CHK("high byte on system_clock", 1'b1, timerIrq)
    wr(ADDR_CTRL, 8'h09);
    lowByteSysclkSelect <= 1'b1;
    repeat (4) @(posedge mclk);
    lowByteSysclkSelect <= 1'b0;
    rd(ADDR_COUNT_LO, rdVal);
    `CHK("split low on system_clock", 8'hFE, rdVal)
    rd(ADDR_CTRL, rdVal);
    `CHK("split low runs stopped", 8'h49, rdVal)
  endtask : split_mode

  // ------------------------------------------------------------
  // verdict
  // ------------------------------------------------------------
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial
  begin
    #50000;
    num_errors++;
    results();
  end

  initial
  begin
    num_errors           = 0;
    n_compared           = 0;
    rst_b                = 1'b0;
    sfrAddr              = 8'h00;
    sfrWrEn              = 1'b0;
    sfrWrData            = 8'h00;
    highByteSysclkSelect = 1'b0;
    lowByteSysclkSelect  = 1'b0;
    timerIrqEnable       = 1'b0;
    extOscIn             = 1'b0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    reset_values();
    register_access();
    irq_gating();
    wrap_16bit();
    split_mode();
    results();
  end

endmodule : reload_timer_tb
